// ### rtl/ucl_cache.sv
`timescale 1ns/1ns

// Function
// - four ways, 256 sets, 16-byte lines, unified
// - per-line valid and dirty flags
// - 22-bit tag from address 28..10 below three zero bits compared
// - fills clear top three tag bits
// - power-on clears flags and lru; manual keeps
// - tags and data never reset
// - set index from address bits 11..4
// - unlocked lru picks victim by fixed table
// - enable bit turns caching on or bypass
// - flush bit invalidates all, reads zero
// - bit 2 picks write-back for region one
// - bit 1 picks write-through for other regions
// - lock register write-only, reads zero
// - dsp prefetch fills way 3 or 2 when loaded
// - prefetch hit is a no-op
// - held ways escape replacement except matching prefetch
// - way 2 held: never replace way 2
// - way 3 held: never replace way 3
// - both held: replace only ways 1, 0
// - hit needs tag match and valid set
module ucl_cache
  import ucl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        power_on,
  // register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // core side
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        prefetch_op,
  input  wire logic        dsp_mode,
  input  wire ucl_region_t acc_region,
  input  wire logic [31:0] acc_addr,
  input  wire logic [31:0] acc_wdata,
  output logic             acc_busy,
  output logic             acc_done,
  output logic             acc_hit,
  output logic      [31:0] acc_rdata,
  // external bus side
  output logic             ext_req,
  output logic             ext_write,
  output logic      [31:0] ext_addr,
  output logic      [31:0] ext_wdata,
  input  wire logic        ext_ack,
  input  wire logic [31:0] ext_rdata
);

  // storage arrays
  logic [TAG_W-1:0] tag_mem  [0:NUM_WAYS*NUM_SETS-1];
  logic [31:0]      data_mem [0:NUM_WAYS*NUM_SETS*LINE_WRDS-1];
  logic [LRU_W-1:0] lru_mem  [0:NUM_SETS-1];
  logic [NUM_WAYS*NUM_SETS-1:0] valid;
  logic [NUM_WAYS*NUM_SETS-1:0] dirty;

  // control state
  logic        cache_on;
  logic        writethrough_sel;
  logic        region_one_writeback_sel;
  logic        way2_hold;
  logic        way2_fill_sel;
  logic        way3_hold;
  logic        way3_fill_sel;

  // request state
  ucl_state_t  state;
  ucl_region_t req_region;
  logic        req_write;
  logic        req_prefetch_op;
  logic        req_dsp;
  logic [31:0] req_addr;
  logic [31:0] req_wdata;
  logic        missed;
  logic [1:0]  victim;
  logic [1:0]  beat;

  // lookup signals
  logic [7:0]       set_idx;
  logic [TAG_W-1:0] look_tag;
  logic [3:0]       hit_vec;
  logic             hit_any;
  logic [1:0]       hit_way;
  logic             wb_mode;
  logic [3:0]       allowed;
  logic [1:0]       next_victim;
  logic             look;
  logic             flush_all;
  logic             ctrl_sel;
  logic             lock_sel;
  logic             write_hit;
  logic             fill_done;
  logic             lru_upd;
  logic [1:0]       lru_way;

  function automatic logic [ENT_W-1:0] ent_idx(input logic [1:0] w, input logic [7:0] s);
    return {w, s};
  endfunction

  // true when way a is older than way b; one bit per pair of ways
  function automatic logic older(input logic [LRU_W-1:0] lru, input logic [1:0] a,
                                 input logic [1:0] b);
    logic       lo_old;
    logic [1:0] lo;
    logic [1:0] hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    case ({lo, hi})
      4'h1:    lo_old = lru[5];
      4'h2:    lo_old = lru[4];
      4'h3:    lo_old = lru[3];
      4'h6:    lo_old = lru[2];
      4'h7:    lo_old = lru[1];
      4'hb:    lo_old = lru[0];
      default: lo_old = 1'b0;
    endcase
    return (a == lo) ? lo_old : !lo_old;
  endfunction

  // way older than every other allowed way; held ways drop out of the contest
  function automatic logic [1:0] pick_way(input logic [LRU_W-1:0] lru,
                                          input logic [3:0] ok_ways);
    logic [1:0] res;
    logic       best;
    res = 2'h0;
    for (int w = 0; w < NUM_WAYS; w++) begin
      best = ok_ways[w];
      for (int v = 0; v < NUM_WAYS; v++) begin
        if (v != w && ok_ways[v] && !older(lru, 2'(w), 2'(v))) begin
          best = 1'b0;
        end
      end
      if (best) begin
        res = 2'(w);
      end
    end
    return res;
  endfunction

  // makes way w newest; legal patterns stay legal
  function automatic logic [LRU_W-1:0] lru_touch(input logic [LRU_W-1:0] lru,
                                                 input logic [1:0] w);
    case (w)
      2'h0:    return {3'h0, lru[2:0]};
      2'h1:    return {1'b1, lru[4:3], 2'h0, lru[0]};
      2'h2:    return {lru[5], 1'b1, lru[3], 1'b1, lru[1], 1'b0};
      default: return {lru[5:4], 1'b1, lru[2], 2'h3};
    endcase
  endfunction

  assign set_idx  = req_addr[11:4];
  assign look_tag = {{SHADOW_W{1'b0}}, req_addr[31-SHADOW_W:10]};
  assign look     = (state == ST_LOOK);

  always_comb begin
    hit_way = 2'h0;
    for (int w = 0; w < NUM_WAYS; w++) begin
      hit_vec[w] = valid[ent_idx(2'(w), set_idx)] &&
                   (tag_mem[ent_idx(2'(w), set_idx)] == look_tag);
      if (hit_vec[w]) begin
        hit_way = 2'(w);
      end
    end
  end
  assign hit_any = |hit_vec;

  // region one follows its own bit
  assign wb_mode = (req_region == PRIV_REGION_ONE) ? region_one_writeback_sel
                                                   : !writethrough_sel;

  assign allowed = {!way3_hold, !way2_hold, 2'h3};

  // loaded way wins for dsp prefetch only
  always_comb begin
    if (req_prefetch_op && req_dsp && way3_hold && way3_fill_sel) begin
      next_victim = 2'h3;
    end else if (req_prefetch_op && req_dsp && way2_hold && way2_fill_sel) begin
      next_victim = 2'h2;
    end else begin
      next_victim = pick_way(lru_mem[set_idx], allowed);
    end
  end

  assign write_hit = look && cache_on && hit_any && req_write && !req_prefetch_op;
  assign fill_done = (state == ST_FILL) && ext_ack && (beat == LAST_BEAT);
  assign lru_upd   = (look && cache_on && hit_any && !req_prefetch_op) || fill_done;
  assign lru_way   = fill_done ? victim : hit_way;

  assign ctrl_sel  = (reg_addr == CTRL_ADDR);
  assign lock_sel  = (reg_addr == LOCK_ADDR);
  assign flush_all = reg_wr && ctrl_sel && reg_wdata[FLUSH_BIT];

  // register writes; both resets load the zero reset values
  always_ff @(posedge mclk) begin
    if (rst) begin
      cache_on                 <= CTRL_RESET[CACHE_ON_BIT];
      writethrough_sel         <= CTRL_RESET[WTHRU_BIT];
      region_one_writeback_sel <= CTRL_RESET[R1_WBACK_BIT];
      way2_hold                <= LOCK_RESET[W2_HOLD_BIT];
      way2_fill_sel            <= LOCK_RESET[W2_FILL_BIT];
      way3_hold                <= LOCK_RESET[W3_HOLD_BIT];
      way3_fill_sel            <= LOCK_RESET[W3_FILL_BIT];
    end else if (reg_wr && ctrl_sel) begin
      cache_on                 <= reg_wdata[CACHE_ON_BIT];
      writethrough_sel         <= reg_wdata[WTHRU_BIT];
      region_one_writeback_sel <= reg_wdata[R1_WBACK_BIT];
    end else if (reg_wr && lock_sel) begin
      way2_hold                <= reg_wdata[W2_HOLD_BIT];
      way2_fill_sel            <= reg_wdata[W2_FILL_BIT];
      way3_hold                <= reg_wdata[W3_HOLD_BIT];
      way3_fill_sel            <= reg_wdata[W3_FILL_BIT];
    end
  end

  // read data valid one cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd && ctrl_sel) begin
      // flush and bits 5,4 read zero
      reg_rdata <= {29'h0, region_one_writeback_sel, writethrough_sel, cache_on};
    end else begin
      // lock register and unmapped read zero
      reg_rdata <= 32'h00000000;
    end
  end

  // flag updates; a fill in the flush cycle survives
  always_ff @(posedge mclk) begin
    if (rst) begin
      if (power_on) begin
        valid <= '0;
        dirty <= '0;
      end
    end else begin
      if (flush_all) begin
        valid <= '0;
        dirty <= '0;
      end
      if (fill_done) begin
        valid[ent_idx(victim, set_idx)] <= 1'b1;
        dirty[ent_idx(victim, set_idx)] <= 1'b0;
      end
      if (write_hit && wb_mode) begin
        dirty[ent_idx(hit_way, set_idx)] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      if (power_on) begin
        for (int s = 0; s < NUM_SETS; s++) begin
          lru_mem[s] <= '0;
        end
      end
    end else if (lru_upd) begin
      lru_mem[set_idx] <= lru_touch(lru_mem[set_idx], lru_way);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst && fill_done) begin
      // tag stored with shadow bits zero
      tag_mem[ent_idx(victim, set_idx)] <= look_tag;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst && state == ST_FILL && ext_ack) begin
      data_mem[{victim, set_idx, beat}] <= ext_rdata;
    end else if (!rst && write_hit) begin
      data_mem[{hit_way, set_idx, req_addr[3:2]}] <= req_wdata;
    end
  end

  // access sequencer; a fill returns to lookup, which then hits
  always_ff @(posedge mclk) begin
    if (rst) begin
      state      <= ST_IDLE;
      req_region <= USER_REGION;
      req_write  <= 1'b0;
      req_prefetch_op   <= 1'b0;
      req_dsp    <= 1'b0;
      req_addr   <= 32'h00000000;
      req_wdata  <= 32'h00000000;
      missed     <= 1'b0;
      victim     <= 2'h0;
      beat       <= 2'h0;
      acc_busy   <= 1'b0;
      acc_done   <= 1'b0;
      acc_hit    <= 1'b0;
      acc_rdata  <= 32'h00000000;
      ext_req    <= 1'b0;
      ext_write  <= 1'b0;
      ext_addr   <= 32'h00000000;
      ext_wdata  <= 32'h00000000;
    end else begin
      acc_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (acc_valid) begin
            req_region <= acc_region;
            req_write  <= acc_write;
            req_prefetch_op   <= prefetch_op;
            req_dsp    <= dsp_mode;
            req_addr   <= acc_addr;
            req_wdata  <= acc_wdata;
            missed     <= 1'b0;
            acc_busy   <= 1'b1;
            state      <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          acc_hit <= cache_on && hit_any && !missed;
          if (req_prefetch_op && (!cache_on || hit_any)) begin
            acc_done <= 1'b1;
            acc_busy <= 1'b0;
            state    <= ST_IDLE;
          end else if (cache_on && hit_any && !req_write) begin
            acc_rdata <= data_mem[{hit_way, set_idx, req_addr[3:2]}];
            acc_done  <= 1'b1;
            acc_busy  <= 1'b0;
            state     <= ST_IDLE;
          end else if (cache_on && hit_any && wb_mode) begin
            acc_done <= 1'b1;
            acc_busy <= 1'b0;
            state    <= ST_IDLE;
          end else if (!cache_on || req_write && (hit_any || !wb_mode)) begin
            ext_req   <= 1'b1;
            ext_write <= req_write;
            ext_addr  <= req_addr;
            ext_wdata <= req_wdata;
            state     <= ST_EXT;
          end else begin
            // miss: line fill, critical order not kept, words 0..3
            missed    <= 1'b1;
            victim    <= next_victim;
            beat      <= 2'h0;
            ext_req   <= 1'b1;
            ext_write <= 1'b0;
            ext_addr  <= {req_addr[31:4], 4'h0};
            state     <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (ext_ack) begin
            beat          <= beat + 2'h1;
            ext_addr[3:2] <= beat + 2'h1;
            if (beat == LAST_BEAT) begin
              ext_req <= 1'b0;
              state   <= ST_LOOK;
            end
          end
        end
        ST_EXT: begin
          if (ext_ack) begin
            ext_req  <= 1'b0;
            acc_done <= 1'b1;
            acc_busy <= 1'b0;
            if (!ext_write) begin
              acc_rdata <= ext_rdata;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ucl_cache

// ### rtl/ucl_pkg.sv
package ucl_pkg;

  // array geometry
  localparam int NUM_WAYS  = 4;
  localparam int NUM_SETS  = 256;
  localparam int LINE_WRDS = 4;
  localparam int TAG_W     = 22;
  localparam int LRU_W     = 6;
  localparam int SHADOW_W  = 3;
  localparam int ENT_W     = 10;
  localparam int DAT_W     = 12;

  // register map (byte addresses)
  localparam logic [31:0] CTRL_ADDR  = 32'hffffffec;
  localparam logic [31:0] LOCK_ADDR  = 32'h040000b0;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] LOCK_RESET = 32'h00000000;

  // cache_control fields
  localparam int CACHE_ON_BIT  = 0;
  localparam int WTHRU_BIT     = 1;
  localparam int R1_WBACK_BIT  = 2;
  localparam int FLUSH_BIT     = 3;

  // cache_way_lock_control fields
  localparam int W2_HOLD_BIT   = 0;
  localparam int W2_FILL_BIT   = 1;
  localparam int W3_HOLD_BIT   = 8;
  localparam int W3_FILL_BIT   = 9;

  localparam logic [1:0] LAST_BEAT = 2'h3;

  typedef enum logic [1:0] {
    USER_REGION      = 2'b00,
    REGION_ZERO      = 2'b01,
    PRIV_REGION_ONE  = 2'b10,
    PRIV_REGION_THREE = 2'b11
  } ucl_region_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_FILL = 2'b10,
    ST_EXT  = 2'b11
  } ucl_state_t;

endpackage

// ### testbench/tb_ucl_cache.sv
`timescale 1ns/1ns
module tb_ucl_cache
  import ucl_pkg::*;
;
  localparam logic [31:0] BASE = 32'h00000120;
  logic        mclk, rst, power_on, reg_wr, reg_rd, acc_valid, acc_write, prefetch_op;
  logic        dsp_mode, slow, acc_busy, acc_done, acc_hit, ext_req, ext_write, ext_ack;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, acc_addr, acc_wdata, acc_rdata;
  logic [31:0] ext_addr, ext_wdata, ext_rdata, dat_s, lv;
  logic [7:0]  wr_count, n;
  logic        hit_s, e;
  ucl_region_t acc_region;
  int          num_errors, checks, m, r, k;

  ucl_cache dut_u (.mclk(mclk), .rst(rst), .power_on(power_on), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc_write(acc_write), .prefetch_op(prefetch_op),
    .dsp_mode(dsp_mode), .acc_region(acc_region), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_busy(acc_busy), .acc_done(acc_done), .acc_hit(acc_hit),
    .acc_rdata(acc_rdata), .ext_req(ext_req), .ext_write(ext_write),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
  ucl_bus_model u_mem (.mclk(mclk), .rst(rst), .ext_req(ext_req), .ext_write(ext_write),
    .ext_addr(ext_addr), .ext_ack(ext_ack), .ext_rdata(ext_rdata), .slow(slow),
    .wr_count(wr_count));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [31:0] a, input logic [31:0] x);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", x, reg_rdata);
  endtask

  task acc(input logic w, input logic p, input ucl_region_t g, input logic [31:0] a,
           input logic [31:0] d);
    int i;
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    prefetch_op <= p;
    acc_region <= g;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge mclk);
    acc_valid <= 1'b0;
    #1;
    for (i = 0; i < 200 && acc_done !== 1'b1; i++) @(posedge mclk) #1;
    hit_s = acc_hit;
    dat_s = acc_rdata;
    chk("acc_done", 32'h1, {31'h0, acc_done});
  endtask

  // read and compare hit flag and word
  task rh(input logic [31:0] a, input logic h);
    acc(1'b0, 1'b0, REGION_ZERO, a, 32'h0);
    chk("acc_hit", {31'h0, h}, {31'h0, hit_s});
    chk("acc_rdata", (a & 32'h1fffffff) ^ 32'h5aa50000, dat_s);
  endtask

  task do_rst(input logic po);
    @(posedge mclk);
    rst <= 1'b1;
    power_on <= po;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
  endtask

  initial begin
    #5000000;
    num_errors++;
    stop_test;
  end

  initial begin
    {reg_wr, reg_rd, acc_valid, acc_write, prefetch_op, dsp_mode, slow} = 7'h0;
    {reg_addr, reg_wdata, acc_addr, acc_wdata} = 128'h0;
    acc_region = REGION_ZERO;
    rst = 1'b1;
    power_on = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(CTRL_ADDR, CTRL_RESET);
    wr(LOCK_ADDR, 32'h1);
    rd(LOCK_ADDR, 32'h0);
    wr(LOCK_ADDR, 32'h0);
    wr(CTRL_ADDR, 32'h0f);
    rd(CTRL_ADDR, 32'h07);
    rd(32'h00001000, 32'h0);
    $display("test registers done");
    wr(CTRL_ADDR, 32'h0);
    rh(BASE, 1'b0);
    wr(CTRL_ADDR, 32'h1);
    rh(BASE, 1'b0);
    rh(BASE, 1'b1);
    rh(BASE | 32'he0000000, 1'b1);
    rh(BASE + 32'h4, 1'b1);
    rh(BASE + 32'h10, 1'b0);
    // lru only set by hardware, never by stimulus
    for (r = 1; r < 5; r++) rh(BASE + 32'(r) * 32'h1000, 1'b0);
    for (r = 1; r < 4; r++) rh(BASE + 32'(r) * 32'h1000, 1'b1);
    rh(BASE, 1'b0);
    rh(BASE + 32'h4000, 1'b0);
    $display("test lookup done");
    // the +3000 line is still resident in way 0, so every write hits
    for (m = 0; m < 4; m++) begin
      wr(CTRL_ADDR, 32'h1 | 32'(m << 1));
      for (r = 0; r < 4; r++) begin
        n = wr_count;
        acc(1'b1, 1'b0, ucl_region_t'(r), BASE + 32'h3000, 32'(m * 4 + r));
        e = (r == 2) ? !m[1] : m[0];
        chk("ext_writes", {31'h0, e}, {24'h0, wr_count - n});
        chk("write_hit", 32'h1, {31'h0, hit_s});
        acc(1'b0, 1'b0, REGION_ZERO, BASE + 32'h3000, 32'h0);
        chk("written_word", 32'(m * 4 + r), dat_s);
      end
    end
    // write misses: write-back allocates, write-through goes to memory only
    wr(CTRL_ADDR, 32'h1);
    n = wr_count;
    acc(1'b1, 1'b0, REGION_ZERO, BASE + 32'h40, 32'h77);
    chk("write_miss", 32'h0, {31'h0, hit_s});
    chk("ext_writes", 32'h0, {24'h0, wr_count - n});
    acc(1'b0, 1'b0, REGION_ZERO, BASE + 32'h40, 32'h0);
    chk("alloc_hit", 32'h1, {31'h0, hit_s});
    chk("alloc_word", 32'h77, dat_s);
    wr(CTRL_ADDR, 32'h3);
    n = wr_count;
    acc(1'b1, 1'b0, REGION_ZERO, BASE + 32'h80, 32'h66);
    chk("write_miss", 32'h0, {31'h0, hit_s});
    chk("ext_writes", 32'h1, {24'h0, wr_count - n});
    rh(BASE + 32'h80, 1'b0);
    $display("test write modes done");
    rh(BASE + 32'h2000, 1'b1);
    wr(CTRL_ADDR, 32'h9);
    rh(BASE + 32'h2000, 1'b0);
    do_rst(1'b0);
    rd(CTRL_ADDR, 32'h0);
    wr(CTRL_ADDR, 32'h1);
    rh(BASE + 32'h2000, 1'b1);
    do_rst(1'b1);
    wr(CTRL_ADDR, 32'h1);
    rh(BASE + 32'h2000, 1'b0);
    $display("test flush and reset done");
    slow <= 1'b1;
    for (k = 0; k < 3; k++) begin
      lv = (k == 0) ? 32'h3 : (k == 1) ? 32'h300 : 32'h103;
      do_rst(1'b1);
      wr(LOCK_ADDR, lv);
      wr(CTRL_ADDR, 32'h1);
      dsp_mode <= 1'b1;
      acc(1'b0, 1'b1, REGION_ZERO, BASE, 32'h0);
      for (r = 1; r < 5; r++) rh(BASE + 32'(r) * 32'h1000, 1'b0);
      acc(1'b0, 1'b1, REGION_ZERO, BASE, 32'h0);
      chk("prefetch_hit", 32'h1, {31'h0, hit_s});
      @(posedge mclk);
      dsp_mode <= 1'b0;
      acc(1'b0, 1'b1, REGION_ZERO, BASE + 32'h5000, 32'h0);
      rh(BASE, 1'b1);
    end
    $display("test locking done");
    stop_test;
  end
endmodule // tb_ucl_cache

// ### testbench/ucl_bus_model.sv
`timescale 1ns/1ns
module ucl_bus_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // bus from the cache
  input  wire logic        ext_req,
  input  wire logic        ext_write,
  input  wire logic [31:0] ext_addr,
  output logic             ext_ack,
  output logic      [31:0] ext_rdata,
  // bench control
  input  wire logic        slow,
  output logic      [7:0]  wr_count
);
  logic [1:0] wait_cnt;
  // undriven between acks: show the inverted word
  assign ext_rdata = ext_ack ? ext_addr ^ 32'h5aa50000 : ~(ext_addr ^ 32'h5aa50000);
  always_ff @(posedge mclk) begin
    if (rst || !ext_req || ext_ack) begin
      wait_cnt <= 2'h0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  // slow mode waits three cycles per word
  always_ff @(posedge mclk) begin
    ext_ack <= !rst && ext_req && !ext_ack && (!slow || wait_cnt == 2'h3);
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_count <= 8'h0;
    end else if (ext_req && ext_ack && ext_write) begin
      wr_count <= wr_count + 8'h1;
    end
  end
endmodule // ucl_bus_model

// ### testbench/ucl_cache_asserts.sv
`timescale 1ns/1ns
module ucl_cache_asserts
  import ucl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        acc_busy,
  input wire logic        acc_done,
  input wire logic        acc_hit,
  input wire logic        ext_req,
  input wire logic        ext_write,
  input wire logic [31:0] ext_addr,
  input wire logic        ext_ack
);
  logic en;
  // shadow of the enable bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      en <= 1'b0;
    end else if (reg_wr && reg_addr == CTRL_ADDR) begin
      en <= reg_wdata[CACHE_ON_BIT];
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero when idle");
  a_ctrl_zeros: assert property ($past(reg_rd) && $past(reg_addr) == CTRL_ADDR
    |-> reg_rdata[5:3] == 3'h0) else $error("control bits 5..3 not zero");
  a_lock_unread: assert property ($past(reg_rd) && $past(reg_addr) == LOCK_ADDR
    |-> reg_rdata == 32'h0) else $error("lock register readable");
  a_busy_done: assert property ($fell(acc_busy) |-> acc_done)
    else $error("busy fell without done");
  a_hit_fast: assert property (acc_done && acc_hit && !$past(ext_req)
    |-> $past(acc_busy) && !$past(acc_busy, 2)) else $error("hit not two cycles");
  a_fill_base: assert property (en && $rose(ext_req) && !ext_write
    |-> ext_addr[3:0] == 4'h0) else $error("fill not at line base");
  a_fill_step: assert property (en && ext_req && ext_ack && !ext_write
    && ext_addr[3:2] != LAST_BEAT |=> ext_req && ext_addr == $past(ext_addr) + 32'h4)
    else $error("fill words not ascending");
  a_req_held: assert property (ext_req && !ext_ack |=> ext_req && $stable(ext_addr))
    else $error("bus request dropped");
  a_write_done: assert property (ext_req && ext_ack && ext_write |=> acc_done)
    else $error("no done after write ack");
  a_bypass_miss: assert property (!en && acc_done |-> !acc_hit)
    else $error("hit while cache off");
  c_hit: cover property (acc_done && acc_hit);
  c_fill: cover property (ext_ack && !ext_write && ext_addr[3:2] == LAST_BEAT);
  c_write: cover property (ext_ack && ext_write);
endmodule // ucl_cache_asserts

bind ucl_cache ucl_cache_asserts u_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .acc_busy(acc_busy), .acc_done(acc_done), .acc_hit(acc_hit), .ext_req(ext_req),
  .ext_write(ext_write), .ext_addr(ext_addr), .ext_ack(ext_ack));
